// file: smw_pkg.sv
// shared constants and types for the supply margin and watchdog command link
package smw_pkg;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
    localparam int unsigned SCL_PERIOD_NS = 10000;
    localparam int unsigned QUARTER_CYCLES = SCL_PERIOD_NS / 4 / CLK_NS;
    localparam logic [10:0] WD_MS_00 = 11'd1280;
    localparam logic [10:0] WD_MS_01 = 11'd320;
    localparam logic [10:0] WD_MS_10 = 11'd80;
    localparam logic [10:0] WD_MS_11 = 11'd20;
    localparam logic [7:0] FIRST_MARGIN = 8'h20;
    localparam logic [7:0] FIRST_WD = 8'h60;
    localparam logic [2:0] MARGIN_FIELD = 3'h1;
    localparam logic [4:0] WD_CMD_PREFIX = 5'h0d;
    localparam int unsigned OP_HI = 7;
    localparam int unsigned OP_LO = 5;
    localparam int unsigned SUPPLY_BIT = 4;
    localparam int unsigned WIN_BIT = 2;
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2a;
    localparam logic [3:0] STEP_RST = 4'h0;
    localparam logic [1:0] WD_PER_RST = 2'h0;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_DATA = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_IRQ_EN = 5'h0c;
    localparam logic [4:0] REG_IRQ_CLR = 5'h10;
    localparam logic [4:0] REG_SLAVE = 5'h14;
    localparam int unsigned CTRL_GO = 0;
    localparam int unsigned CTRL_LEN_LO = 1;
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_NACK = 1;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_RECV = 2'b01,
        D_ACK = 2'b11,
        D_SKIP = 2'b10
    } dev_state_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_MARGIN = 2'b01,
        OP_WD = 2'b11
    } op_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BIT = 3'b011,
        H_ACK = 3'b010,
        H_STOP = 3'b110
    } host_state_t;
endpackage : smw_pkg

// file: i2c_link_if.sv
// open-drain two-wire link between controller and device
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;
    logic scl_h_o;
    logic scl_h_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // pull-up wins unless an enabled driver pulls low
    assign scl = ~(scl_h_oe & ~scl_h_o);
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
    modport host (output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe,
        input scl, input sda);
    modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

// file: supply_margin_watchdog_cmd.sv
// device end: command interpreter for margining and watchdog over the link
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - each write needs a guard first command
// - first commands 001 00000 and 011 00000
// - several margining bytes after one first
// - 001 00101 sets linear regulator step five
// - 001 11100 sets switcher step twelve
// - watchdog byte 01101WPP, window and period
// - valid watchdog byte starts the timer
// - later byte clears only while window open
// - clear and new setting in one step
// - watchdog first twice disables the timer
// - any period byte restarts a disabled timer
// - master refreshes the watchdog periodically
// - only the master ends with stop
// - after stop return idle, await start
// - master addresses device in write mode
// - first command follows address acknowledge
module supply_margin_watchdog_cmd
    import smw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
    input wire logic core_clk,
    input wire logic rstn,
    i2c_link_if.device link,
    output logic [3:0] ldo_step,
    output logic [3:0] sw_step,
    output logic wd_on,
    output logic wd_window,
    output logic [1:0] wd_period,
    output logic wd_fault
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        dev_state_t st;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [3:0] bits;
        logic [1:0] idx;
        logic [7:0] sh;
        op_t op;
        logic sda_low;
        logic [3:0] ldo;
        logic [3:0] sw;
        logic wd_on;
        logic win;
        logic [1:0] per;
        logic [TW-1:0] tick;
        logic [10:0] ms;
        logic fault;
    } dev_t;

    dev_t s;
    dev_t n;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic wd_cmd;
    logic wd_off;
    logic closed;
    logic [10:0] per_ms;

    function automatic logic [10:0] period_ms(input logic [1:0] pp);
        case (pp)
            2'b00: period_ms = WD_MS_00;
            2'b01: period_ms = WD_MS_01;
            2'b10: period_ms = WD_MS_10;
            default: period_ms = WD_MS_11;
        endcase
    endfunction : period_ms

    always_comb begin
        n = s;
        n.fault = 1'b0;
        wd_cmd = 1'b0;
        wd_off = 1'b0;
        // the second and third stages are read, the first only feeds them
        n.scl_m = link.scl;
        n.scl_s = s.scl_m;
        n.scl_p = s.scl_s;
        n.sda_m = link.sda;
        n.sda_s = s.sda_m;
        n.sda_p = s.sda_s;
        rise = s.scl_s & ~s.scl_p;
        fall = ~s.scl_s & s.scl_p;
        start = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
        stop = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
        case (s.st)
            D_IDLE: begin
                n.sda_low = 1'b0;
            end
            D_RECV: begin
                if (rise && s.bits < 4'd8) begin
                    n.sh = {s.sh[6:0], s.sda_s};
                    n.bits = s.bits + 4'd1;
                end
                if (fall && s.bits == 4'd8) begin
                    n.st = D_ACK;
                    n.sda_low = 1'b1;
                    case (s.idx)
                        2'd0: begin
                            // read requests are not served, stay silent
                            if (s.sh[7:1] != SLAVE_ADDR || s.sh[0]) begin
                                n.st = D_SKIP;
                                n.sda_low = 1'b0;
                            end
                        end
                        2'd1: begin
                            // byte right after address ack picks the operation
                            if (s.sh == FIRST_MARGIN) begin
                                n.op = OP_MARGIN;
                            end else if (s.sh == FIRST_WD) begin
                                n.op = OP_WD;
                            end else begin
                                // no guard, no command: refuse the rest
                                n.st = D_SKIP;
                                n.sda_low = 1'b0;
                            end
                        end
                        default: begin
                            if (s.op == OP_MARGIN && s.sh[OP_HI:OP_LO] == MARGIN_FIELD) begin
                                // value msb picks the supply, low nibble the step
                                if (s.sh[SUPPLY_BIT]) begin
                                    n.sw = s.sh[3:0];
                                end else begin
                                    n.ldo = s.sh[3:0];
                                end
                            end else if (s.op == OP_WD && s.sh == FIRST_WD) begin
                                wd_off = 1'b1;
                            end else if (s.op == OP_WD && s.sh[7:3] == WD_CMD_PREFIX) begin
                                wd_cmd = 1'b1;
                            end
                            // anything else is acked but leaves settings alone
                        end
                    endcase
                    if (s.idx != 2'd2) begin
                        n.idx = s.idx + 2'd1;
                    end
                end
            end
            D_ACK: begin
                if (fall) begin
                    n.st = D_RECV;
                    n.sda_low = 1'b0;
                    n.bits = 4'd0;
                end
            end
            D_SKIP: begin
                n.sda_low = 1'b0;
            end
            default: begin
                n.st = D_IDLE;
                n.sda_low = 1'b0;
            end
        endcase
        if (start) begin
            n.st = D_RECV;
            n.bits = 4'd0;
            n.idx = 2'd0;
            n.op = OP_NONE;
            n.sda_low = 1'b0;
        end else if (stop) begin
            // back to idle until the next start
            n.st = D_IDLE;
            n.op = OP_NONE;
            n.sda_low = 1'b0;
        end

        per_ms = period_ms(s.per);
        // window opens in the second half of the running period
        closed = s.wd_on & s.win & (s.ms < (per_ms >> 1));
        if (wd_cmd) begin
            // one accepted byte clears and reloads together
            n.wd_on = 1'b1;
            n.win = s.sh[WIN_BIT];
            n.per = s.sh[1:0];
            // early refresh faults and must not buy extra time
            if (!closed) begin
                n.tick = '0;
                n.ms = 11'd0;
            end
            n.fault = closed;
        end else if (wd_off) begin
            n.wd_on = 1'b0;
            n.tick = '0;
            n.ms = 11'd0;
        end else if (s.wd_on) begin
            if (s.tick == TW'(TICK_CYCLES - 1)) begin
                n.tick = '0;
                if (s.ms >= per_ms - 11'd1) begin
                    n.ms = 11'd0;
                    n.fault = 1'b1;
                end else begin
                    n.ms = s.ms + 11'd1;
                end
            end else begin
                n.tick = s.tick + TW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{
                st: D_IDLE,
                scl_m: 1'b1,
                scl_s: 1'b1,
                scl_p: 1'b1,
                sda_m: 1'b1,
                sda_s: 1'b1,
                sda_p: 1'b1,
                bits: 4'h0,
                idx: 2'h0,
                sh: 8'h00,
                op: OP_NONE,
                sda_low: 1'b0,
                ldo: STEP_RST,
                sw: STEP_RST,
                wd_on: 1'b0,
                win: 1'b0,
                per: WD_PER_RST,
                tick: '0,
                ms: 11'h000,
                fault: 1'b0
            };
        end else begin
            s <= n;
        end
    end

    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = s.sda_low;
    assign ldo_step = s.ldo;
    assign sw_step = s.sw;
    assign wd_on = s.wd_on;
    assign wd_window = s.win;
    assign wd_period = s.per;
    assign wd_fault = s.fault;
endmodule : supply_margin_watchdog_cmd
`default_nettype wire

// file: i2c_cmd_master.sv
// controller end: avalon register front, sends guarded command writes
`timescale 1ns/1ns
`default_nettype none
module i2c_cmd_master
    import smw_pkg::*;
#(
    parameter int unsigned QUARTER = QUARTER_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    i2c_link_if.host link
);
    localparam int unsigned QW = $clog2(QUARTER + 1);

    if (QUARTER < 2) begin : g_bad_quarter
        $error("QUARTER must be at least 2");
    end

    typedef struct packed {
        host_state_t st;
        logic sda_m;
        logic sda_s;
        logic [QW-1:0] div;
        logic [1:0] ph;
        logic [2:0] bits;
        logic [1:0] idx;
        logic [1:0] len;
        logic [7:0] sh;
        logic [31:0] data;
        logic [6:0] slave;
        logic [1:0] status;
        logic [1:0] irq_en;
        logic irq;
        logic scl_low;
        logic sda_low;
        logic wait_n;
        logic waitreq;
        logic [31:0] rdata;
    } host_t;

    host_t s;
    host_t n;
    logic q;
    logic req;
    logic [31:0] be_mask;
    logic [1:0] set_ev;
    logic [1:0] clr_ev;

    always_comb begin
        n = s;
        set_ev = 2'b00;
        clr_ev = 2'b00;
        be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        n.sda_m = link.sda;
        n.sda_s = s.sda_m;
        q = (s.div == QW'(QUARTER - 1));
        n.div = q ? '0 : s.div + QW'(1);
        if (q && s.st != H_IDLE) begin
            n.ph = s.ph + 2'd1;
            case (s.st)
                H_START: begin
                    if (s.ph == 2'd0) n.sda_low = 1'b1;
                    if (s.ph == 2'd2) n.scl_low = 1'b1;
                    if (s.ph == 2'd3) n.st = H_BIT;
                end
                H_BIT: begin
                    if (s.ph == 2'd0) n.sda_low = ~s.sh[7];
                    if (s.ph == 2'd1) n.scl_low = 1'b0;
                    if (s.ph == 2'd3) begin
                        n.scl_low = 1'b1;
                        n.sh = {s.sh[6:0], 1'b0};
                        n.bits = s.bits + 3'd1;
                        if (s.bits == 3'd7) n.st = H_ACK;
                    end
                end
                H_ACK: begin
                    if (s.ph == 2'd0) n.sda_low = 1'b0;
                    if (s.ph == 2'd1) n.scl_low = 1'b0;
                    if (s.ph == 2'd2 && s.sda_s) set_ev[ST_NACK] = 1'b1;
                    if (s.ph == 2'd3) begin
                        n.scl_low = 1'b1;
                        if (s.status[ST_NACK] || set_ev[ST_NACK] || s.idx == s.len) begin
                            n.st = H_STOP;
                        end else begin
                            n.st = H_BIT;
                            n.idx = s.idx + 2'd1;
                            n.sh = s.data[8 * s.idx +: 8];
                        end
                    end
                end
                H_STOP: begin
                    if (s.ph == 2'd0) n.sda_low = 1'b1;
                    if (s.ph == 2'd1) n.scl_low = 1'b0;
                    if (s.ph == 2'd2) n.sda_low = 1'b0;
                    if (s.ph == 2'd3) begin
                        n.st = H_IDLE;
                        set_ev[ST_DONE] = 1'b1;
                    end
                end
                default: n.st = H_IDLE;
            endcase
        end
        // one wait cycle, then the answer stands for a single edge
        req = avs_read | avs_write;
        n.wait_n = req & ~s.wait_n;
        n.waitreq = ~(req & ~s.wait_n);
        if (req && !s.wait_n) begin
            case (avs_address)
                REG_CTRL: n.rdata = {31'd0, s.st != H_IDLE};
                REG_DATA: n.rdata = s.data;
                REG_STATUS: n.rdata = {30'd0, s.status};
                REG_IRQ_EN: n.rdata = {30'd0, s.irq_en};
                REG_SLAVE: n.rdata = {25'd0, s.slave};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && s.wait_n) begin
            case (avs_address)
                REG_CTRL: begin
                    // a go while busy is dropped
                    if (avs_byteenable[0] && avs_writedata[CTRL_GO] && s.st == H_IDLE) begin
                        n.st = H_START;
                        n.ph = 2'd0;
                        n.div = '0;
                        n.bits = 3'd0;
                        n.idx = 2'd0;
                        n.len = avs_writedata[CTRL_LEN_LO +: 2];
                        n.sh = {s.slave, 1'b0};
                        clr_ev[ST_NACK] = 1'b1;
                    end
                end
                REG_DATA: n.data = (s.data & ~be_mask) | (avs_writedata & be_mask);
                REG_IRQ_EN: if (avs_byteenable[0]) n.irq_en = avs_writedata[1:0];
                REG_IRQ_CLR: if (avs_byteenable[0]) clr_ev = clr_ev | avs_writedata[1:0];
                REG_SLAVE: if (avs_byteenable[0]) n.slave = avs_writedata[6:0];
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        n.status = (s.status & ~clr_ev) | set_ev;
        n.irq = |(n.status & n.irq_en);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{
                st: H_IDLE,
                sda_m: 1'b1,
                sda_s: 1'b1,
                div: '0,
                ph: 2'h0,
                bits: 3'h0,
                idx: 2'h0,
                len: 2'h0,
                sh: 8'h00,
                data: DATA_RST,
                slave: DEF_SLAVE_ADDR,
                status: 2'h0,
                irq_en: IRQ_EN_RST,
                irq: 1'b0,
                scl_low: 1'b0,
                sda_low: 1'b0,
                wait_n: 1'b0,
                waitreq: 1'b1,
                rdata: 32'h0000_0000
            };
        end else begin
            s <= n;
        end
    end

    assign link.scl_h_o = 1'b0;
    assign link.scl_h_oe = s.scl_low;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe = s.sda_low;
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign irq = s.irq;
endmodule : i2c_cmd_master
`default_nettype wire

// file: smw_link_monitor.sv
// concurrent checks on the link wires and the device settings
`timescale 1ns/1ns
`default_nettype none
module smw_link_monitor (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_d_oe,
    input wire logic [3:0] ldo_step,
    input wire logic [3:0] sw_step,
    input wire logic wd_on,
    input wire logic wd_window,
    input wire logic [1:0] wd_period,
    input wire logic wd_fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // device may only move its data line while the clock is low
    a_ack_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device data line moved with clock high");
    a_ack_full_bit: assert property ($rose(sda_d_oe) |=> sda_d_oe [*8])
        else $error("acknowledge released too early");
    a_stop_idle: assert property (scl && $past(scl) && $rose(sda) |-> !sda_d_oe [*8])
        else $error("device drove the line after a stop");
    a_step_at_fall: assert property (
        ($changed(ldo_step) || $changed(sw_step)) |-> !scl)
        else $error("margin step changed outside a byte end");
    a_one_supply: assert property ($changed(ldo_step) |-> $stable(sw_step))
        else $error("both supplies changed at once");
    a_wd_start_fall: assert property ($rose(wd_on) |-> !scl)
        else $error("watchdog started outside a byte end");
    a_wd_load_together: assert property (
        ($changed(wd_period) || $changed(wd_window)) |-> !scl && wd_on)
        else $error("watchdog setting loaded apart from a command");
    a_wd_off_fall: assert property ($fell(wd_on) |-> !scl)
        else $error("watchdog stopped outside a byte end");
    a_fault_pulse: assert property (wd_fault |=> !wd_fault)
        else $error("fault longer than one cycle");
    a_fault_running: assert property (wd_fault |-> $past(wd_on))
        else $error("fault while watchdog was off");
endmodule : smw_link_monitor
`default_nettype wire

// file: tb_supply_margin_watchdog_cmd.sv
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ns
`default_nettype none
module tb_supply_margin_watchdog_cmd;
    import smw_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, wd_on, wd_window, wd_fault;
    logic [3:0] ldo_step, sw_step, e_ldo = 4'h0, e_sw = 4'h0;
    logic [1:0] wd_period, e_per = 2'h0, ien = 2'h0;
    logic e_on = 1'b0;
    logic e_win = 1'b0;
    logic [31:0] seed = 32'hc02e0ac1;
    int failures = 0;
    int n_tests = 0;
    int n_fault = 0;
    i2c_link_if link ();
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (wd_fault === 1'b1) n_fault++;
    supply_margin_watchdog_cmd #(.TICK_CYCLES(10)) u_supply_margin_watchdog_cmd (
        .core_clk(core_clk), .rstn(rstn), .link(link.device), .ldo_step(ldo_step),
        .sw_step(sw_step), .wd_on(wd_on), .wd_window(wd_window), .wd_period(wd_period),
        .wd_fault(wd_fault));
    i2c_cmd_master #(.QUARTER(4)) u_i2c_cmd_master (
        .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .link(link.host));
    smw_link_monitor u_smw_link_monitor (
        .core_clk(core_clk), .rstn(rstn), .scl(link.scl), .sda(link.sda),
        .sda_d_oe(link.sda_d_oe), .ldo_step(ldo_step), .sw_step(sw_step), .wd_on(wd_on),
        .wd_window(wd_window), .wd_period(wd_period), .wd_fault(wd_fault));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr
    task automatic report_and_stop;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= ~rd;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) failures++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic apply(input logic [7:0] f, input logic [7:0] c);
        if (f == FIRST_MARGIN && c[OP_HI:OP_LO] == MARGIN_FIELD) begin
            if (c[SUPPLY_BIT]) e_sw = c[3:0];
            else e_ldo = c[3:0];
        end else if (f == FIRST_WD && c == FIRST_WD) begin
            e_on = 1'b0;
        end else if (f == FIRST_WD && c[7:3] == WD_CMD_PREFIX) begin
            e_on = 1'b1;
            e_win = c[WIN_BIT];
            e_per = c[1:0];
        end
    endtask : apply
    task automatic outs;
        chk("ldo_step", 32'(e_ldo), 32'(ldo_step));
        chk("sw_step", 32'(e_sw), 32'(sw_step));
        chk("wd_on", 32'(e_on), 32'(wd_on));
        chk("wd_window", 32'(e_win), 32'(wd_window));
        chk("wd_period", 32'(e_per), 32'(wd_period));
    endtask : outs
    // whole transfer: first command plus up to two command bytes
    task automatic xfer(input logic [7:0] b0, b1, b2, input logic [1:0] n, input logic nack);
        logic [31:0] q;
        int k;
        k = 0;
        bus(1'b0, REG_DATA, {8'h00, b2, b1, b0}, q);
        bus(1'b0, REG_CTRL, {29'h0, n, 1'b1}, q);
        do begin
            bus(1'b1, REG_CTRL, 32'h0, q);
            k++;
        end while (q[0] !== 1'b0 && k < 2000);
        if (k >= 2000) failures++;
        bus(1'b1, REG_STATUS, 32'h0, q);
        chk("status", {30'h0, nack, 1'b1}, q);
        chk("irq", 32'(|(ien & {nack, 1'b1})), 32'(irq));
        bus(1'b0, REG_IRQ_CLR, 32'h3, q);
        if (!nack && n[1]) apply(b0, b1);
        if (!nack && n == 2'd3) apply(b0, b2);
        outs();
    endtask : xfer
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q;
        int f0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        outs();
        bus(1'b1, REG_SLAVE, 32'h0, q);
        chk("slave", {25'h0, DEF_SLAVE_ADDR}, q);
        bus(1'b1, 5'h1c, 32'h0, q);
        chk("unmapped", 32'h0, q);
        bus(1'b0, REG_DATA, 32'h1122_3344, q);
        avs_byteenable <= 4'h5;
        bus(1'b0, REG_DATA, 32'haabb_ccdd, q);
        avs_byteenable <= 4'hf;
        bus(1'b1, REG_DATA, 32'h0, q);
        chk("byte lanes", 32'h11bb_33dd, q);
        $display("test reset done");
        xfer(FIRST_MARGIN, 8'h25, 8'h3c, 2'd3, 1'b0);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            xfer(FIRST_MARGIN, {3'b001, seed[4:0]}, {3'b001, seed[12:8]},
                {1'b1, seed[16]}, 1'b0);
        end
        xfer(FIRST_MARGIN, 8'h69, 8'h00, 2'd2, 1'b0);
        xfer(FIRST_WD, 8'h25, 8'h00, 2'd2, 1'b0);
        $display("test margining done");
        // unguarded write and a foreign address are both refused
        xfer(8'h25, 8'h3c, 8'h00, 2'd2, 1'b1);
        bus(1'b0, REG_SLAVE, 32'h11, q);
        xfer(FIRST_MARGIN, 8'h21, 8'h00, 2'd2, 1'b1);
        bus(1'b0, REG_SLAVE, {25'h0, DEF_SLAVE_ADDR}, q);
        xfer(FIRST_MARGIN, 8'h31, 8'h00, 2'd2, 1'b0);
        $display("test refusal done");
        for (int i = 0; i < 8; i++) xfer(FIRST_WD, 8'h68 | 8'(i), 8'h00, 2'd2, 1'b0);
        xfer(FIRST_WD, FIRST_WD, 8'h00, 2'd2, 1'b0);
        xfer(FIRST_WD, 8'h6b, 8'h00, 2'd2, 1'b0);
        f0 = n_fault;
        repeat (450) @(posedge core_clk);
        chk("expiry", 32'h1, 32'(n_fault > f0));
        chk("wd_on", 32'h1, 32'(wd_on));
        $display("test watchdog codes done");
        // refresh too early faults, refresh in the second half does not
        xfer(FIRST_WD, 8'h6c, 8'h00, 2'd2, 1'b0);
        f0 = n_fault;
        xfer(FIRST_WD, 8'h6c, 8'h00, 2'd2, 1'b0);
        chk("closed window", 32'(f0 + 1), 32'(n_fault));
        repeat (7000) @(posedge core_clk);
        f0 = n_fault;
        xfer(FIRST_WD, 8'h6d, 8'h00, 2'd2, 1'b0);
        chk("open window", 32'(f0), 32'(n_fault));
        $display("test window done");
        ien = 2'h1;
        bus(1'b0, REG_IRQ_EN, 32'h1, q);
        xfer(FIRST_MARGIN, 8'h22, 8'h00, 2'd2, 1'b0);
        @(posedge core_clk);
        chk("irq cleared", 32'h0, 32'(irq));
        ien = 2'h2;
        bus(1'b0, REG_IRQ_EN, 32'h2, q);
        xfer(FIRST_MARGIN, 8'h33, 8'h00, 2'd2, 1'b0);
        xfer(8'h00, 8'h33, 8'h00, 2'd2, 1'b1);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule : tb_supply_margin_watchdog_cmd
`default_nettype wire
